// ### vgsc_regs.svh
// Constants for the protector self-check block.
// Assumes inclusion by the package and the design module only.
`ifndef VGSC_REGS_SVH
`define VGSC_REGS_SVH
`define VGSC_NUM_CH        8
`define VGSC_THR_W         8
`define VGSC_MODE_W        2
`define VGSC_MODE_BIST     2'h2
`define VGSC_MODE_SINGLE   2'h3
`define VGSC_MODE_OFF      2'h0
`define VGSC_DAC_NUM       4
`define VGSC_DAC_DEN       5
`define VGSC_SETTLE_NS     50
`define VGSC_CLK_NS        5
`define VGSC_SETTLE_CYC    ((`VGSC_SETTLE_NS + `VGSC_CLK_NS - 1) / `VGSC_CLK_NS)
`define VGSC_PAR_PERIOD    16
`endif

// ### vgsc_pkg.sv
// Types for the protector self-check block.
// Assumes vgsc_regs.svh is on the include path.
`include "vgsc_regs.svh"
package vgsc_pkg;
    typedef struct packed {
        logic [`VGSC_MODE_W-1:0] mode;
        logic [`VGSC_THR_W-1:0]  ov_thr;
        logic [`VGSC_THR_W-1:0]  uv_thr;
    } vgsc_cfg_t;

    typedef struct packed {
        logic                    config_parity_fail;
        logic                    over_comparator_fail;
        logic                    under_comparator_fail;
        logic [`VGSC_NUM_CH-1:0] voltage_path_fail;
        logic                    self_test_abort;
    } vgsc_flags_t;

    typedef enum logic [3:0] {
        VGSC_IDLE, VGSC_PRECHK, VGSC_CMP_HI, VGSC_CMP_LO, VGSC_UV_SET, VGSC_UV_CHK,
        VGSC_UV_CLR, VGSC_OV_SET, VGSC_OV_CHK, VGSC_OV_CLR, VGSC_DONE
    } vgsc_state_t;
endpackage

// ### vgsc_self_check.sv
// Protector self-check: parity guard, DAC readback, built-in self-test.
// Assumes analog comparators and fault logic outside, inputs synchronous to i_core_clk.
// Summary of operation
// - Latch config on go, check it every 16 cycles
// - Parity mismatch sets configuration parity fail flag
// - Route OV/UV DAC values to aux ADC
// - DAC reading equals threshold times 0.8
// - Mode 0b10 with go starts self-test
// - Test comparators above/below; flag failures
// - Open each active channel input, check UV and pin
// - Clear UV bit, release pin, next channel
// - UV path failure sets voltage path flag
// - Force each active channel's OV bit, check bit and pin
// - Comparators off at end; 0b11 resumes
// - New go mid-test follows current mode
// - Pre-existing fault before comparator test aborts
// - Keep-faults option leaves bits and pin asserted
// - Fault pin toggles per path when enabled
`timescale 1ns/100ps
`include "vgsc_regs.svh"
module vgsc_self_check
#(
    parameter int NUM_CH = `VGSC_NUM_CH,
    parameter int THR_W  = `VGSC_THR_W
)
(
    // Clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_sys_rst,
    // Host control
    input  wire vgsc_pkg::vgsc_cfg_t  i_protector_control,
    input  wire logic                 i_protector_go,
    input  wire logic [NUM_CH-1:0]    i_active_channels,
    input  wire logic [3:0]           i_protector_channel_lock,
    input  wire logic                 i_self_test_keep_faults,
    input  wire logic                 i_fault_pin_enable,
    input  wire logic                 i_flags_clear,
    // Analog side
    input  wire logic                 i_ov_comp_out,
    input  wire logic                 i_uv_comp_out,
    input  wire logic [NUM_CH-1:0]    i_uv_fault_raw,
    input  wire logic [NUM_CH-1:0]    i_ov_fault_raw,
    // Protector drive
    output logic                      o_protector_enable,
    output logic [1:0]                o_comp_test_level,
    output logic [NUM_CH-1:0]         o_mux_input_open,
    output logic [NUM_CH-1:0]         o_ov_force,
    output logic                      o_fault_clear,
    output logic [THR_W-1:0]          o_ov_dac_aux,
    output logic [THR_W-1:0]          o_uv_dac_aux,
    output logic [3:0]                o_aux_dac_channel,
    // Status
    output logic [NUM_CH-1:0]         o_under_voltage_fault_flags,
    output logic [NUM_CH-1:0]         o_over_voltage_fault_flags,
    output logic                      o_fault_out_n,
    output vgsc_pkg::vgsc_flags_t     o_flags,
    output logic                      o_self_test_busy
);
    import vgsc_pkg::*;

    localparam int CW = $clog2(NUM_CH);
    localparam int SETTLE = `VGSC_SETTLE_CYC;

    vgsc_cfg_t           latch_q, latch_d;
    logic                par_q, par_d;
    logic [3:0]          ptick_q, ptick_d;
    logic                run_q, run_d;
    vgsc_flags_t         flg_q, flg_d;
    vgsc_state_t         st_q, st_d;
    logic [CW-1:0]       ch_q, ch_d;
    logic [7:0]          wait_q, wait_d;
    logic [1:0]          lvl_q, lvl_d;
    logic [NUM_CH-1:0]   open_q, open_d, force_q, force_d;
    logic                clr_q, clr_d;
    logic [NUM_CH-1:0]   uvf_q, uvf_d, ovf_q, ovf_d;
    logic                pin_q, pin_d;
    logic [THR_W-1:0]    ovdac_q, ovdac_d, uvdac_q, uvdac_d;
    logic                settled;
    logic                any_fault;

    assign settled = (wait_q == 8'(SETTLE));
    assign any_fault = (|i_uv_fault_raw) | (|i_ov_fault_raw);

    // Latch, parity and DAC readback
    always_comb
    begin
        latch_d = latch_q;
        par_d = par_q;
        run_d = run_q;
        ptick_d = ptick_q + 4'h1;
        ovdac_d = THR_W'((32'(latch_q.ov_thr) * `VGSC_DAC_NUM) / `VGSC_DAC_DEN);
        uvdac_d = THR_W'((32'(latch_q.uv_thr) * `VGSC_DAC_NUM) / `VGSC_DAC_DEN);
        if (i_protector_go)
        begin
            latch_d = i_protector_control;
            par_d = ^i_protector_control;
            run_d = (i_protector_control.mode != `VGSC_MODE_OFF);
        end
        else if (st_q == VGSC_DONE)
        begin
            run_d = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            latch_q <= '0;
            par_q <= 1'b0;
            run_q <= 1'b0;
            ptick_q <= 4'h0;
            ovdac_q <= '0;
            uvdac_q <= '0;
        end
        else
        begin
            latch_q <= latch_d;
            par_q <= par_d;
            run_q <= run_d;
            ptick_q <= ptick_d;
            ovdac_q <= ovdac_d;
            uvdac_q <= uvdac_d;
        end
    end

    // Self-test sequencer and sticky flags
    always_comb
    begin
        st_d = st_q;
        ch_d = ch_q;
        wait_d = settled ? wait_q : wait_q + 8'h01;
        lvl_d = lvl_q;
        open_d = '0;
        force_d = '0;
        clr_d = 1'b0;
        flg_d = flg_q;
        uvf_d = i_uv_fault_raw;
        ovf_d = i_ov_fault_raw;
        pin_d = any_fault;
        if (i_flags_clear)
        begin
            flg_d = '0;
        end
        if (run_q && ptick_q == 4'hF && (^latch_q != par_q))
        begin
            flg_d.config_parity_fail = 1'b1;
        end
        unique case (st_q)
            VGSC_IDLE:
            begin
                lvl_d = 2'h0;
            end
            VGSC_PRECHK:
            begin
                if (any_fault)
                begin
                    flg_d.self_test_abort = 1'b1;
                    st_d = VGSC_DONE;
                end
                else
                begin
                    lvl_d = 2'h2;
                    wait_d = 8'h00;
                    st_d = VGSC_CMP_HI;
                end
            end
            VGSC_CMP_HI:
            begin
                if (settled)
                begin
                    if (!i_ov_comp_out || i_uv_comp_out)
                    begin
                        flg_d.over_comparator_fail = !i_ov_comp_out | flg_d.over_comparator_fail;
                        flg_d.under_comparator_fail = i_uv_comp_out | flg_d.under_comparator_fail;
                    end
                    lvl_d = 2'h1;
                    wait_d = 8'h00;
                    st_d = VGSC_CMP_LO;
                end
            end
            VGSC_CMP_LO:
            begin
                if (settled)
                begin
                    if (i_ov_comp_out)
                        flg_d.over_comparator_fail = 1'b1;
                    if (!i_uv_comp_out)
                        flg_d.under_comparator_fail = 1'b1;
                    lvl_d = 2'h0;
                    ch_d = '0;
                    wait_d = 8'h00;
                    st_d = VGSC_UV_SET;
                end
            end
            VGSC_UV_SET:
            begin
                if (!i_active_channels[ch_q])
                begin
                    st_d = VGSC_UV_CLR;
                end
                else
                begin
                    open_d[ch_q] = 1'b1;
                    if (settled)
                        st_d = VGSC_UV_CHK;
                end
            end
            VGSC_UV_CHK:
            begin
                open_d[ch_q] = 1'b1;
                if (!i_uv_fault_raw[ch_q] || !(i_fault_pin_enable ? any_fault : 1'b1))
                    flg_d.voltage_path_fail[ch_q] = 1'b1;
                st_d = VGSC_UV_CLR;
            end
            VGSC_UV_CLR:
            begin
                clr_d = !i_self_test_keep_faults;
                wait_d = 8'h00;
                if (ch_q == CW'(NUM_CH - 1))
                begin
                    ch_d = '0;
                    st_d = VGSC_OV_SET;
                end
                else
                begin
                    ch_d = ch_q + 1'b1;
                    st_d = VGSC_UV_SET;
                end
            end
            VGSC_OV_SET:
            begin
                force_d[ch_q] = i_active_channels[ch_q];
                if (!i_active_channels[ch_q])
                    st_d = VGSC_OV_CLR;
                else if (settled)
                    st_d = VGSC_OV_CHK;
            end
            VGSC_OV_CHK:
            begin
                force_d[ch_q] = 1'b1;
                if (!i_ov_fault_raw[ch_q] || !any_fault)
                    flg_d.voltage_path_fail[ch_q] = 1'b1;
                st_d = VGSC_OV_CLR;
            end
            VGSC_OV_CLR:
            begin
                clr_d = !i_self_test_keep_faults;
                wait_d = 8'h00;
                ch_d = ch_q + 1'b1;
                if (ch_q == CW'(NUM_CH - 1))
                    st_d = VGSC_DONE;
                else
                    st_d = VGSC_OV_SET;
            end
            VGSC_DONE:
            begin
                lvl_d = 2'h0;
                st_d = VGSC_IDLE;
            end
        endcase
        if (i_protector_go)
        begin
            ch_d = '0;
            wait_d = 8'h00;
            lvl_d = 2'h0;
            st_d = (i_protector_control.mode == `VGSC_MODE_BIST) ? VGSC_PRECHK : VGSC_IDLE;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_q <= VGSC_IDLE;
            ch_q <= '0;
            wait_q <= 8'h00;
            lvl_q <= 2'h0;
            open_q <= '0;
            force_q <= '0;
            clr_q <= 1'b0;
            flg_q <= '0;
            uvf_q <= '0;
            ovf_q <= '0;
            pin_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            ch_q <= ch_d;
            wait_q <= wait_d;
            lvl_q <= lvl_d;
            open_q <= open_d;
            force_q <= force_d;
            clr_q <= clr_d;
            flg_q <= flg_d;
            uvf_q <= uvf_d;
            ovf_q <= ovf_d;
            pin_q <= pin_d;
        end
    end

    assign o_protector_enable = run_q;
    assign o_comp_test_level = lvl_q;
    assign o_mux_input_open = open_q;
    assign o_ov_force = force_q;
    assign o_fault_clear = clr_q;
    assign o_ov_dac_aux = ovdac_q;
    assign o_uv_dac_aux = uvdac_q;
    assign o_aux_dac_channel = i_protector_channel_lock;
    assign o_under_voltage_fault_flags = uvf_q;
    assign o_over_voltage_fault_flags = ovf_q;
    assign o_fault_out_n = !(pin_q && i_fault_pin_enable);
    assign o_flags = flg_q;
    assign o_self_test_busy = (st_q != VGSC_IDLE);
endmodule

// ### vgsc_chk.sv
// Checker: port-level properties of the protector self-check block.
// Assumes a bind onto vgsc_self_check from the bench top.
`timescale 1ns/100ps
module vgsc_chk
#(
    parameter int NUM_CH = 8,
    parameter int THR_W  = 8
)
(
    // Watched inputs
    input wire logic                  i_core_clk,
    input wire logic                  i_sys_rst,
    input wire vgsc_pkg::vgsc_cfg_t   i_protector_control,
    input wire logic                  i_protector_go,
    input wire logic [3:0]            i_protector_channel_lock,
    input wire logic                  i_fault_pin_enable,
    input wire logic                  i_flags_clear,
    input wire logic [NUM_CH-1:0]     i_uv_fault_raw,
    input wire logic [NUM_CH-1:0]     i_ov_fault_raw,
    // Watched outputs
    input wire logic                  o_protector_enable,
    input wire logic [NUM_CH-1:0]     o_mux_input_open,
    input wire logic [NUM_CH-1:0]     o_ov_force,
    input wire logic [THR_W-1:0]      o_ov_dac_aux,
    input wire logic [THR_W-1:0]      o_uv_dac_aux,
    input wire logic [3:0]            o_aux_dac_channel,
    input wire logic                  o_fault_out_n,
    input wire vgsc_pkg::vgsc_flags_t o_flags,
    input wire logic                  o_self_test_busy
);
    import vgsc_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    a_busy_after_go: assert property (i_protector_go && i_protector_control.mode == 2'h2 |=> o_self_test_busy)
        else $error("busy missing after self-test go");
    a_enable_after_go: assert property (i_protector_go && i_protector_control.mode != 2'h0 |=> o_protector_enable)
        else $error("protector not enabled after go");
    a_go_restart: assert property (o_self_test_busy && i_protector_go && i_protector_control.mode != 2'h2
        |=> !o_self_test_busy)
        else $error("self-test kept running after other go");
    a_dac_scale: assert property (i_protector_go ##1 !i_protector_go
        |=> o_ov_dac_aux == $past(i_protector_control.ov_thr, 2) * 4 / 5
        && o_uv_dac_aux == $past(i_protector_control.uv_thr, 2) * 4 / 5)
        else $error("dac readback not scaled");
    a_aux_channel: assert property (o_aux_dac_channel == i_protector_channel_lock)
        else $error("aux channel not the locked one");
    a_pin_low: assert property ($past(|(i_uv_fault_raw | i_ov_fault_raw)) && $past(i_fault_pin_enable)
        && i_fault_pin_enable |-> !o_fault_out_n)
        else $error("fault pin high with a fault");
    a_flags_sticky: assert property (!i_flags_clear |=> (o_flags & $past(o_flags)) == $past(o_flags))
        else $error("flag dropped without clear");
    a_drive_onehot: assert property ($onehot0(o_mux_input_open) && $onehot0(o_ov_force))
        else $error("more than one channel driven");
    a_done_off: assert property ($fell(o_self_test_busy) && !$past(i_protector_go) |-> !o_protector_enable)
        else $error("protector left on after self-test");
endmodule

// ### vgsc_self_check_test.sv
// Bench for the protector self-check block with a small analog stand-in.
// Assumes vgsc_pkg, vgsc_self_check and vgsc_chk are compiled first.
`timescale 1ns/100ps
module vgsc_self_check_test;
    import vgsc_pkg::*;
    logic        clk, rst, go, keep, clr, cmp_ok, en, fclr, fout_n, busy, pen;
    logic [1:0]  lvl;
    logic [3:0]  lock, auxch;
    logic [7:0]  act, pre, uvg, ovg, uv_q, ov_q, mopen, frc, ovdac, uvdac, uvf, ovf, r;
    vgsc_cfg_t   cfg;
    vgsc_flags_t flags;
    int          num_errors = 0;
    int          checks_done = 0;
    int          tog;
    vgsc_self_check vgsc_self_check_i
    (
        .i_core_clk(clk), .i_sys_rst(rst), .i_protector_control(cfg), .i_protector_go(go),
        .i_active_channels(act), .i_protector_channel_lock(lock), .i_self_test_keep_faults(keep),
        .i_fault_pin_enable(pen), .i_flags_clear(clr), .i_ov_comp_out(lvl == 2'h2 && cmp_ok),
        .i_uv_comp_out(lvl == 2'h1), .i_uv_fault_raw(uv_q | pre), .i_ov_fault_raw(ov_q),
        .o_protector_enable(en), .o_comp_test_level(lvl), .o_mux_input_open(mopen), .o_ov_force(frc),
        .o_fault_clear(fclr), .o_ov_dac_aux(ovdac), .o_uv_dac_aux(uvdac), .o_aux_dac_channel(auxch),
        .o_under_voltage_fault_flags(uvf), .o_over_voltage_fault_flags(ovf), .o_fault_out_n(fout_n),
        .o_flags(flags), .o_self_test_busy(busy)
    );
    // Latching fault bits of the protector, broken paths masked out
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            uv_q <= 8'h00;
            ov_q <= 8'h00;
        end
        else
        begin
            uv_q <= (uv_q | (mopen & uvg)) & ~{8{fclr | clr}};
            ov_q <= (ov_q | (frc & ovg)) & ~{8{fclr | clr}};
        end
    always @(fout_n) tog++;
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] dac(input logic [7:0] t);
        return 8'((16'(t) * 16'h0004) / 16'h0005);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test;
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic start(input logic [1:0] m);
        r = nxt(r);
        cfg = {m, r, nxt(r)};
        lock = r[3:0];
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
    endtask
    task automatic clear_all;
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
    endtask
    task automatic bist(input logic [7:0] a);
        int n;
        act = a;
        tog = 0;
        start(2'h2);
        chk("busy", 1, busy);
        for (n = 0; n < 3000 && busy !== 1'b0; n++)
            @(negedge clk);
        repeat (3) @(negedge clk);
        chk("finish", 1, n < 3000);
    endtask
    initial
    begin
        #100000;
        num_errors++;
        stop_test;
    end
    initial
    begin
        {go, keep, clr, pre, act, lock, cfg} = '0;
        cmp_ok = 1'b1;
        pen = 1'b1;
        uvg = 8'hFF;
        ovg = 8'hFF;
        r = 8'h1E;
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk("flags", 0, flags);
        chk("pin", 1, fout_n);
        repeat (6)
        begin
            start(2'h3);
            @(negedge clk);
            chk("ov_dac", dac(cfg.ov_thr), ovdac);
            chk("uv_dac", dac(cfg.uv_thr), uvdac);
            chk("aux_ch", lock, auxch);
            chk("enable", 1, en);
        end
        repeat (40) @(negedge clk);
        chk("parity", 0, flags.config_parity_fail);
        start(2'h0);
        @(negedge clk);
        chk("off", 0, en);
        bist(nxt(r) | 8'h01);
        chk("flags", 0, flags);
        chk("toggles", 4 * $countones(act), tog);
        chk("uv_flags", 0, uvf);
        chk("enable", 0, en);
        uvg = 8'hFB;
        ovg = 8'hEF;
        cmp_ok = 1'b0;
        bist(8'hFF);
        repeat (30) @(negedge clk);
        chk("path", 8'h14, flags.voltage_path_fail);
        chk("ov_cmp", 1, flags.over_comparator_fail);
        chk("uv_cmp", 0, flags.under_comparator_fail);
        clear_all;
        chk("cleared", 0, flags);
        {uvg, ovg, cmp_ok} = {8'hFF, 8'hFF, 1'b1};
        keep = 1'b1;
        bist(8'h5A);
        chk("kept", 8'h5A, uvf);
        chk("pin_kept", 0, fout_n);
        chk("ov_kept", 8'h5A, ovf);
        keep = 1'b0;
        clear_all;
        @(negedge clk);
        pre = 8'h01;
        bist(8'hFF);
        chk("abort", 1, flags.self_test_abort);
        chk("no_path", 0, flags.voltage_path_fail);
        pre = 8'h00;
        clear_all;
        start(2'h2);
        repeat (5) @(negedge clk);
        start(2'h3);
        chk("restart", 0, busy);
        chk("run_mode", 1, en);
        pen = 1'b0;
        bist(8'h0F);
        chk("pin_off", 0, tog);
        chk("path_off", 0, flags);
        pen = 1'b1;
        stop_test;
    end
endmodule
bind vgsc_self_check vgsc_chk #(.NUM_CH(NUM_CH), .THR_W(THR_W)) vgsc_chk_i
(
    .i_core_clk, .i_sys_rst, .i_protector_control, .i_protector_go, .i_protector_channel_lock,
    .i_fault_pin_enable, .i_flags_clear, .i_uv_fault_raw, .i_ov_fault_raw, .o_protector_enable,
    .o_mux_input_open, .o_ov_force, .o_ov_dac_aux, .o_uv_dac_aux, .o_aux_dac_channel, .o_fault_out_n,
    .o_flags, .o_self_test_busy
);
